// file: core/nsi_pkg.sv
// Shared constants and types of the network status indicator.
package nsi_pkg;

  // Timebase figures in their own units.
  localparam int NSI_CLK_PERIOD_NS = 25;
  localparam int NSI_MS_NS = 1000000;
  // Clock cycles in one millisecond tick.
  localparam int NSI_TICK_CYCLES = NSI_MS_NS / NSI_CLK_PERIOD_NS;

  // Width of the per-LED millisecond phase counter.
  localparam int NSI_CNT_W = 11;
  // Pattern phase lengths in milliseconds.
  localparam logic [NSI_CNT_W-1:0] NSI_FLICKER_MS = 11'd50;
  localparam logic [NSI_CNT_W-1:0] NSI_BLINK_MS = 11'd200;
  localparam logic [NSI_CNT_W-1:0] NSI_FLASH_ON_MS = 11'd200;
  localparam logic [NSI_CNT_W-1:0] NSI_FLASH_GAP_MS = 11'd200;
  localparam logic [NSI_CNT_W-1:0] NSI_FLASH_OFF_MS = 11'd1000;
  // Last counter value of each pattern period, and the start and end of the second double flash.
  localparam logic [NSI_CNT_W-1:0] NSI_FLICKER_LAST = NSI_CNT_W'(2 * NSI_FLICKER_MS - 1);
  localparam logic [NSI_CNT_W-1:0] NSI_BLINK_LAST = NSI_CNT_W'(2 * NSI_BLINK_MS - 1);
  localparam logic [NSI_CNT_W-1:0] NSI_SINGLE_LAST = NSI_CNT_W'(NSI_FLASH_ON_MS
                                                     + NSI_FLASH_OFF_MS - 1);
  localparam logic [NSI_CNT_W-1:0] NSI_SECOND_ON = NSI_CNT_W'(NSI_FLASH_ON_MS + NSI_FLASH_GAP_MS);
  localparam logic [NSI_CNT_W-1:0] NSI_SECOND_OFF = NSI_CNT_W'(NSI_SECOND_ON + NSI_FLASH_ON_MS);
  localparam logic [NSI_CNT_W-1:0] NSI_DOUBLE_LAST = NSI_CNT_W'(NSI_SECOND_OFF
                                                     + NSI_FLASH_OFF_MS - 1);

  // Register bus geometry and byte offsets.
  localparam int NSI_ADDR_W = 4;
  localparam logic [NSI_ADDR_W-1:0] NSI_CTRL_OFS = 4'h0;
  localparam logic [NSI_ADDR_W-1:0] NSI_ERR_OFS = 4'h4;
  localparam logic [NSI_ADDR_W-1:0] NSI_DISP_OFS = 4'h8;
  localparam logic [NSI_ADDR_W-1:0] NSI_STAT_OFS = 4'hC;

  // Field positions.
  localparam int NSI_CTRL_STATE_LSB = 0;
  localparam int NSI_CTRL_SAFETY_BIT = 2;
  localparam int NSI_ERR_REFUSED_BIT = 0;
  localparam int NSI_ERR_AUTO_BIT = 1;
  localparam int NSI_ERR_SMWDT_BIT = 2;
  localparam int NSI_ERR_CRIT_BIT = 3;
  localparam int NSI_DISP_TEST_BIT = 0;
  localparam int NSI_DISP_CPU_BIT = 1;
  localparam int NSI_DISP_INIT_BIT = 2;
  localparam int NSI_DISP_CONN_LSB = 8;
  localparam int NSI_STAT_DISP_LSB = 16;

  // Slave state machine encodings held in the control register.
  localparam logic [1:0] NSI_ST_INIT = 2'h0;
  localparam logic [1:0] NSI_ST_PREOP = 2'h1;
  localparam logic [1:0] NSI_ST_SAFEOP = 2'h2;
  localparam logic [1:0] NSI_ST_OP = 2'h3;

  // Reset values of the writable registers.
  localparam logic [31:0] NSI_REG_RST = 32'h0000_0000;

  // LED lighting patterns.
  typedef enum logic [2:0] {
    NSI_PAT_OFF, NSI_PAT_ON, NSI_PAT_FLICKER, NSI_PAT_BLINK, NSI_PAT_SINGLE, NSI_PAT_DOUBLE
  } nsi_pat_e;

  // Special indications selected for the status display.
  typedef enum logic [2:0] {
    NSI_DISP_NORMAL, NSI_DISP_NOT_CONN, NSI_DISP_TEST, NSI_DISP_CPU_ERR, NSI_DISP_INIT
  } nsi_disp_e;

  // One register bus request.
  typedef struct packed {
    logic [NSI_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } nsi_bus_req_s;

endpackage

// file: core/nsi_indicator.sv
`timescale 1ns/100ps

// Overview of operation
// - Steady on stays lit, off stays dark.
// - Flicker: 50 ms on, 50 ms off.
// - Blink: 200 ms on, 200 ms off.
// - Single flash: 200 ms on, 1000 off.
// - Double flash: on, off, on, long off.
// - Run LED off in Init or unpowered.
// - Run LED blinks in Pre-Operational.
// - Run LED single-flashes in Safe-Operational.
// - Run LED steady in Operational.
// - Error LED off clean, blinks on refusal.
// - Error LED single-flashes on autonomous change.
// - Error LED double-flashes on sync watchdog.
// - Error LED steady on critical error.
// - Link LED off unpowered or no link.
// - Link LED steady when idle link.
// - Link LED flickers with traffic.
// - Line fault LED lit during receive errors.
// - Safety LED lit when safety activatable.
// - Display shows test, CPU error, init.
// - Not-connected shown separately per axis.
module nsi_indicator
  import nsi_pkg::*;
#(
  parameter int NUM_PORTS = 2,
  parameter int NUM_AXES = 3,
  parameter int TICK_CYCLES = NSI_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register bus.
  input wire nsi_bus_req_s bus_req_i,
  output logic [31:0] bus_rdata_o,
  // Power and port status.
  input wire logic power_ok_i,
  input wire logic [NUM_PORTS-1:0] link_up_i,
  input wire logic [NUM_PORTS-1:0] traffic_i,
  input wire logic [NUM_PORTS-1:0] rx_error_i,
  // Indicator LEDs.
  output logic run_state_led_o,
  output logic comm_error_led_o,
  output logic [NUM_PORTS-1:0] link_led_o,
  output logic [NUM_PORTS-1:0] line_fault_led_o,
  output logic safety_ready_led_o,
  // Status display.
  output nsi_disp_e disp_code_o,
  output logic [NUM_AXES-1:0] disp_nc_axis_o
);

  // LED slots of the pattern engine: run, error, then one per port.
  localparam int NUM_LEDS = 2 + NUM_PORTS;
  localparam int LED_RUN = 0;
  localparam int LED_ERR = 1;
  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // Writable registers and the read data holder.
  logic [31:0] ctrl_reg;
  logic [31:0] err_reg;
  logic [31:0] disp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Millisecond timebase.
  logic [TW-1:0] div_reg;
  logic tick_reg;

  // Per-LED pattern selection, phase counter and lit level.
  nsi_pat_e pat_next [NUM_LEDS];
  nsi_pat_e pat_reg [NUM_LEDS];
  logic [NSI_CNT_W-1:0] cnt_reg [NUM_LEDS];
  logic [NUM_LEDS-1:0] led_reg;

  // Steady LEDs and display outputs.
  logic [NUM_PORTS-1:0] fault_reg;
  logic safety_reg;
  nsi_disp_e disp_reg_code;
  nsi_disp_e disp_next;
  logic [NUM_AXES-1:0] nc_reg;

  // Decoded fields of the control registers.
  wire logic [1:0] esm_state = ctrl_reg[NSI_CTRL_STATE_LSB +: 2];
  wire logic safety_ok = ctrl_reg[NSI_CTRL_SAFETY_BIT];
  wire logic err_refused = err_reg[NSI_ERR_REFUSED_BIT];
  wire logic err_auto = err_reg[NSI_ERR_AUTO_BIT];
  wire logic err_smwdt = err_reg[NSI_ERR_SMWDT_BIT];
  wire logic err_crit = err_reg[NSI_ERR_CRIT_BIT];
  wire logic show_test = disp_reg[NSI_DISP_TEST_BIT];
  wire logic show_cpu = disp_reg[NSI_DISP_CPU_BIT];
  wire logic show_init = disp_reg[NSI_DISP_INIT_BIT];
  wire logic [NUM_AXES-1:0] axis_conn = disp_reg[NSI_DISP_CONN_LSB +: NUM_AXES];

  // Address decode of the bus strobes.
  wire logic hit_ctrl = bus_req_i.addr == NSI_CTRL_OFS;
  wire logic hit_err = bus_req_i.addr == NSI_ERR_OFS;
  wire logic hit_disp = bus_req_i.addr == NSI_DISP_OFS;
  wire logic hit_stat = bus_req_i.addr == NSI_STAT_OFS;

  // Status word that software reads back.
  wire logic [31:0] stat_word = (32'(led_reg)) | (32'(fault_reg) << NUM_LEDS)
                                | (32'(safety_reg) << (NUM_LEDS + NUM_PORTS))
                                | (32'(disp_reg_code) << NSI_STAT_DISP_LSB);

  // Lit level of a pattern at a given millisecond of its period.
  function automatic logic pat_level(input nsi_pat_e p, input logic [NSI_CNT_W-1:0] c);
    logic lvl;
    lvl = 1'b0;
    case (p)
      NSI_PAT_ON: lvl = 1'b1;
      NSI_PAT_FLICKER: lvl = c < NSI_FLICKER_MS;
      NSI_PAT_BLINK: lvl = c < NSI_BLINK_MS;
      NSI_PAT_SINGLE: lvl = c < NSI_FLASH_ON_MS;
      NSI_PAT_DOUBLE: lvl = (c < NSI_FLASH_ON_MS) || (c >= NSI_SECOND_ON && c < NSI_SECOND_OFF);
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  // Last counter value before a pattern period wraps.
  function automatic logic [NSI_CNT_W-1:0] pat_last(input nsi_pat_e p);
    logic [NSI_CNT_W-1:0] l;
    l = '0;
    case (p)
      NSI_PAT_FLICKER: l = NSI_FLICKER_LAST;
      NSI_PAT_BLINK: l = NSI_BLINK_LAST;
      NSI_PAT_SINGLE: l = NSI_SINGLE_LAST;
      NSI_PAT_DOUBLE: l = NSI_DOUBLE_LAST;
      default: l = '0;
    endcase
    return l;
  endfunction

  // Register writes; software holds each condition as a level.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_reg <= NSI_REG_RST;
      err_reg <= NSI_REG_RST;
      disp_reg <= NSI_REG_RST;
    end else if (bus_req_i.wr) begin
      if (hit_ctrl) ctrl_reg <= bus_req_i.wdata;
      if (hit_err) err_reg <= bus_req_i.wdata;
      if (hit_disp) disp_reg <= bus_req_i.wdata;
    end
  end

  // Read mux; unmapped offsets and idle cycles return zero.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (bus_req_i.rd) begin
      if (hit_ctrl) rdata_next = ctrl_reg;
      else if (hit_err) rdata_next = err_reg;
      else if (hit_disp) rdata_next = disp_reg;
      else if (hit_stat) rdata_next = stat_word;
      else rdata_next = 32'h0000_0000;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) rdata_reg <= 32'h0000_0000;
    else rdata_reg <= rdata_next;
  end

  // Free-running divider that pulses once per millisecond.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= (div_reg == TICK_LAST) ? '0 : div_reg + 1'b1;
      tick_reg <= div_reg == TICK_LAST;
    end
  end

  // Run LED follows the slave state; no power forces it dark.
  always_comb begin
    if (!power_ok_i) pat_next[LED_RUN] = NSI_PAT_OFF;
    else begin
      case (esm_state)
        NSI_ST_PREOP: pat_next[LED_RUN] = NSI_PAT_BLINK;
        NSI_ST_SAFEOP: pat_next[LED_RUN] = NSI_PAT_SINGLE;
        NSI_ST_OP: pat_next[LED_RUN] = NSI_PAT_ON;
        default: pat_next[LED_RUN] = NSI_PAT_OFF;
      endcase
    end
  end

  // Error LED shows the most severe active condition.
  always_comb begin
    if (err_crit) pat_next[LED_ERR] = NSI_PAT_ON;
    else if (err_smwdt) pat_next[LED_ERR] = NSI_PAT_DOUBLE;
    else if (err_auto) pat_next[LED_ERR] = NSI_PAT_SINGLE;
    else if (err_refused) pat_next[LED_ERR] = NSI_PAT_BLINK;
    else pat_next[LED_ERR] = NSI_PAT_OFF;
  end

  // Pattern engine, one copy per LED slot plus the port link selection.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_link
      // Link LED: dark without power or link, flicker on traffic.
      always_comb begin
        if (!power_ok_i || !link_up_i[gi]) pat_next[2 + gi] = NSI_PAT_OFF;
        else if (traffic_i[gi]) pat_next[2 + gi] = NSI_PAT_FLICKER;
        else pat_next[2 + gi] = NSI_PAT_ON;
      end
    end
    for (gi = 0; gi < NUM_LEDS; gi++) begin : g_led
      // A new pattern restarts at its on phase; else count ticks.
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pat_reg[gi] <= NSI_PAT_OFF;
          cnt_reg[gi] <= '0;
          led_reg[gi] <= 1'b0;
        end else begin
          pat_reg[gi] <= pat_next[gi];
          if (pat_next[gi] != pat_reg[gi]) cnt_reg[gi] <= '0;
          else if (tick_reg) begin
            cnt_reg[gi] <= (cnt_reg[gi] >= pat_last(pat_reg[gi])) ? '0 : cnt_reg[gi] + 1'b1;
          end
          led_reg[gi] <= pat_level(pat_reg[gi], cnt_reg[gi]);
        end
      end
    end
  endgenerate

  // Display selection; fault indications outrank the connection view.
  always_comb begin
    if (show_cpu) disp_next = NSI_DISP_CPU_ERR;
    else if (show_init) disp_next = NSI_DISP_INIT;
    else if (show_test) disp_next = NSI_DISP_TEST;
    else if (axis_conn != {NUM_AXES{1'b1}}) disp_next = NSI_DISP_NOT_CONN;
    else disp_next = NSI_DISP_NORMAL;
  end

  // Steady LEDs and display outputs are registered.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_reg <= '0;
      safety_reg <= 1'b0;
      disp_reg_code <= NSI_DISP_NORMAL;
      nc_reg <= '0;
    end else begin
      fault_reg <= rx_error_i;
      safety_reg <= safety_ok;
      disp_reg_code <= disp_next;
      nc_reg <= ~axis_conn;
    end
  end

  // Output connections, all from flip-flops.
  assign bus_rdata_o = rdata_reg;
  assign run_state_led_o = led_reg[LED_RUN];
  assign comm_error_led_o = led_reg[LED_ERR];
  assign link_led_o = led_reg[NUM_LEDS-1:2];
  assign line_fault_led_o = fault_reg;
  assign safety_ready_led_o = safety_reg;
  assign disp_code_o = disp_reg_code;
  assign disp_nc_axis_o = nc_reg;

  // Checks on the pattern engine and selections.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  tick_spacing_a: assert property (tick_reg |=> !tick_reg [*8])
    else $error("millisecond tick repeated too soon");
  restart_phase_a: assert property (pat_reg[LED_ERR] != $past(pat_reg[LED_ERR])
                                    |-> cnt_reg[LED_ERR] == '0)
    else $error("pattern change did not restart phase");
  run_unpowered_a: assert property (!power_ok_i [*2] |=> !run_state_led_o)
    else $error("run LED lit without power");
  run_oper_a: assert property (power_ok_i && esm_state == NSI_ST_OP
                               |=> pat_reg[LED_RUN] == NSI_PAT_ON ##1 run_state_led_o)
    else $error("run LED not steady in operational");
  flicker_off_a: assert property (pat_reg[2] == NSI_PAT_FLICKER && cnt_reg[2] == 11'd50
                                  && $past(pat_reg[2]) == NSI_PAT_FLICKER
                                  |=> !link_led_o[0])
    else $error("flicker on phase too long");
  blink_edge_a: assert property (pat_reg[LED_RUN] == NSI_PAT_BLINK && cnt_reg[LED_RUN] == 11'd199
                                 |=> run_state_led_o)
    else $error("blink on phase too short");
  single_dark_a: assert property (pat_reg[LED_RUN] == NSI_PAT_SINGLE
                                  && cnt_reg[LED_RUN] == 11'd700 |=> !run_state_led_o)
    else $error("single flash lit in off phase");
  double_second_a: assert property (pat_reg[LED_ERR] == NSI_PAT_DOUBLE
                                    && cnt_reg[LED_ERR] == 11'd450 |=> comm_error_led_o)
    else $error("double flash second pulse missing");
  err_crit_a: assert property (err_crit [*2] |=> comm_error_led_o)
    else $error("critical error not steady");
  err_prio_a: assert property (err_smwdt && !err_crit
                               |=> pat_reg[LED_ERR] == NSI_PAT_DOUBLE)
    else $error("sync watchdog pattern not chosen");
  link_idle_a: assert property (power_ok_i && link_up_i[0] && !traffic_i[0]
                                |=> pat_reg[2] == NSI_PAT_ON)
    else $error("idle link not steady");
  fault_led_a: assert property (rx_error_i[0] |=> line_fault_led_o[0])
    else $error("line fault LED not lit");
  safety_led_a: assert property (safety_ok != safety_ready_led_o
                                 |=> safety_ready_led_o == $past(safety_ok))
    else $error("safety LED does not follow");
  disp_cpu_a: assert property (show_cpu |=> disp_code_o == NSI_DISP_CPU_ERR)
    else $error("CPU error not displayed");
  axis_nc_a: assert property (!axis_conn[0] |=> disp_nc_axis_o[0])
    else $error("axis not-connected not shown");
  read_once_a: assert property (!bus_req_i.rd |=> bus_rdata_o == 32'h0000_0000)
    else $error("read data outlived its cycle");

  cov_double_c: cover property (pat_reg[LED_ERR] == NSI_PAT_DOUBLE
                                && cnt_reg[LED_ERR] == NSI_SECOND_ON);
  cov_single_wrap_c: cover property (pat_reg[LED_RUN] == NSI_PAT_SINGLE
                                     && cnt_reg[LED_RUN] == NSI_SINGLE_LAST ##1 tick_reg);
  cov_flicker_c: cover property (pat_reg[2] == NSI_PAT_FLICKER && link_led_o[0]);
  cov_not_conn_c: cover property (disp_code_o == NSI_DISP_NOT_CONN);

endmodule

// file: sim/nsi_led_panel.sv
`timescale 1ns/100ps

// Front panel model: the lamps that an operator sees, high = glowing.
module nsi_led_panel
  import nsi_pkg::*;
#(
  parameter int NUM_PORTS = 2
) (
  // LED drive from the indicator.
  input wire logic run_led_i,
  input wire logic err_led_i,
  input wire logic [NUM_PORTS-1:0] link_led_i,
  // Lamp states: run, error, then one link lamp per port.
  output logic [NUM_PORTS+1:0] lamps_o
);
  // A lamp follows its drive line with no memory of its own.
  assign lamps_o = {link_led_i, err_led_i, run_led_i};
endmodule

// file: sim/tb_nsi_indicator.sv
`timescale 1ns/100ps

// Self-checking bench for the indicator, with a short millisecond tick.
module tb_nsi_indicator
  import nsi_pkg::*;
;
  localparam int TICK = 10; // Cycles per simulated millisecond.
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  nsi_bus_req_s bus_req = '0;
  logic [31:0] bus_rdata;
  logic power_ok = 1'b0;
  logic [1:0] link_up = 2'h0;
  logic [1:0] traffic = 2'h0;
  logic [1:0] rx_error = 2'h0;
  logic run_led, err_led, safety_led;
  logic [1:0] link_led, fault_led;
  nsi_disp_e disp_code;
  logic [2:0] disp_nc;
  logic [3:0] lamps;
  int mismatches = 0;
  int checked = 0;

  // Half period of 12.5 ns gives 40 MHz.
  always #12.5 clk_i = ~clk_i;

  nsi_indicator #(.NUM_PORTS(2), .NUM_AXES(3), .TICK_CYCLES(TICK)) i_nsi_indicator (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_req_i(bus_req), .bus_rdata_o(bus_rdata),
    .power_ok_i(power_ok), .link_up_i(link_up), .traffic_i(traffic), .rx_error_i(rx_error),
    .run_state_led_o(run_led), .comm_error_led_o(err_led), .link_led_o(link_led),
    .line_fault_led_o(fault_led), .safety_ready_led_o(safety_led),
    .disp_code_o(disp_code), .disp_nc_axis_o(disp_nc));

  nsi_led_panel #(.NUM_PORTS(2)) i_nsi_led_panel (
    .run_led_i(run_led), .err_led_i(err_led), .link_led_i(link_led), .lamps_o(lamps));

  // Prints the counts and the verdict, then stops the run.
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compares one value and reports a difference at once.
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_req.wr <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // One-cycle read strobe; data is taken in the following cycle only.
  task automatic bus_read(input logic [3:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_i);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_req.rd <= 1'b0;
    #1 compare(what, exp, bus_rdata);
  endtask

  // A lamp must keep one level for longer than any on phase of a pattern.
  task automatic check_hold(input int idx, input logic lvl, input string what);
    logic seen;
    seen = lvl;
    // A new input level reaches the lamp only two edges later, so skip those.
    repeat (2) @(posedge clk_i);
    repeat (2100) begin
      @(posedge clk_i);
      #1 if (lamps[idx] !== lvl) seen = lamps[idx];
    end
    compare(what, {31'h0, lvl}, {31'h0, seen});
  endtask

  // Counts cycles while a lamp stays at one level, with a bound.
  task automatic run_len(input int idx, input logic lvl, output int len);
    len = 0;
    while (lamps[idx] === lvl && len < 12000) begin
      @(posedge clk_i);
      #1 len++;
    end
  endtask

  // Skips the first, possibly short, on phase and measures the phases after it.
  task automatic check_seq(input int idx, input string what, input int np, input int d[4]);
    int len;
    run_len(idx, 1'b0, len);
    run_len(idx, 1'b1, len);
    for (int k = 0; k < np; k++) begin
      run_len(idx, logic'(k % 2), len);
      compare(what, 32'(d[k] * TICK), 32'(len));
    end
  endtask

  // Writes the display register and checks the selected indication.
  task automatic disp_check(input logic [31:0] d, input nsi_disp_e code, input logic [2:0] nc);
    bus_write(NSI_DISP_OFS, d);
    compare("display code", 32'(code), 32'(disp_code));
    compare("axis not connected", 32'(nc), 32'(disp_nc));
  endtask

  // Watchdog sized about a quarter above the expected length of all tests.
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    $display("watchdog expired");
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 compare("axis not connected", 32'h7, 32'(disp_nc));
    bus_read(NSI_CTRL_OFS, NSI_REG_RST, "control reset");
    bus_read(NSI_ERR_OFS, NSI_REG_RST, "error reset");
    bus_read(NSI_DISP_OFS, NSI_REG_RST, "display reset");
    bus_write(4'h2, 32'hFFFF_FFFF);
    bus_read(4'h2, 32'h0, "unmapped read");
    $display("test reset done");

    // Run lamp follows the slave state.
    @(posedge clk_i);
    power_ok <= 1'b1;
    bus_write(NSI_CTRL_OFS, 32'h0);
    check_hold(0, 1'b0, "run lamp init");
    bus_write(NSI_CTRL_OFS, 32'h1);
    check_seq(0, "run blink", 3, '{200, 200, 200, 0});
    bus_write(NSI_CTRL_OFS, 32'h2);
    check_seq(0, "run single", 2, '{1000, 200, 0, 0});
    bus_write(NSI_CTRL_OFS, 32'h7);
    compare("safety lamp", 32'h1, {31'h0, safety_led});
    check_hold(0, 1'b1, "run lamp operational");
    @(posedge clk_i);
    power_ok <= 1'b0;
    check_hold(0, 1'b0, "run lamp unpowered");
    @(posedge clk_i);
    power_ok <= 1'b1;
    bus_write(NSI_CTRL_OFS, 32'h3);
    compare("safety lamp", 32'h0, {31'h0, safety_led});
    $display("test run lamp done");

    // Error lamp follows the error cause.
    bus_write(NSI_ERR_OFS, 32'h0);
    check_hold(1, 1'b0, "error lamp clean");
    bus_write(NSI_ERR_OFS, 32'h1);
    check_seq(1, "error blink", 2, '{200, 200, 0, 0});
    bus_write(NSI_ERR_OFS, 32'h2);
    check_seq(1, "error single", 2, '{1000, 200, 0, 0});
    bus_write(NSI_ERR_OFS, 32'h4);
    check_seq(1, "error double", 3, '{200, 200, 1000, 0});
    bus_write(NSI_ERR_OFS, 32'h8);
    check_hold(1, 1'b1, "error lamp critical");
    bus_write(NSI_ERR_OFS, 32'h0);
    $display("test error lamp done");

    // Link lamps per port.
    @(posedge clk_i);
    traffic <= 2'h3;
    check_hold(2, 1'b0, "link lamp no link");
    @(posedge clk_i);
    link_up <= 2'h1;
    traffic <= 2'h0;
    check_hold(2, 1'b1, "link lamp idle");
    compare("link lamp other port", 32'h0, {31'h0, lamps[3]});
    @(posedge clk_i);
    traffic <= 2'h1;
    check_seq(2, "link flicker", 4, '{50, 50, 50, 50});
    @(posedge clk_i);
    link_up <= 2'h2;
    traffic <= 2'h0;
    check_hold(3, 1'b1, "second link lamp idle");
    @(posedge clk_i);
    power_ok <= 1'b0;
    check_hold(3, 1'b0, "link lamp unpowered");
    $display("test link lamps done");

    // Line fault lamps follow received errors per port.
    @(posedge clk_i);
    rx_error <= 2'h1;
    repeat (3) @(posedge clk_i);
    #1 compare("line fault lamps", 32'h1, 32'(fault_led));
    @(posedge clk_i);
    rx_error <= 2'h2;
    repeat (3) @(posedge clk_i);
    #1 compare("line fault lamps", 32'h2, 32'(fault_led));
    $display("test line fault done");

    // Status display indications.
    disp_check(32'h0000_0700, NSI_DISP_NORMAL, 3'h0);
    disp_check(32'h0000_0300, NSI_DISP_NOT_CONN, 3'h4);
    disp_check(32'h0000_0701, NSI_DISP_TEST, 3'h0);
    disp_check(32'h0000_0704, NSI_DISP_INIT, 3'h0);
    disp_check(32'h0000_0707, NSI_DISP_CPU_ERR, 3'h0);
    // Pattern lamps dark, port 1 line fault lit, safety dark, CPU error on the display.
    bus_read(NSI_STAT_OFS, (32'(NSI_DISP_CPU_ERR) << NSI_STAT_DISP_LSB) | 32'h0000_0020,
             "status");
    $display("test display done");
    summarize();
  end
endmodule
